// File: spd_desc_events.sv
// Purpose: Descriptor status and event reporting of a serial peripheral port.
// Assumes: Shifter pulses arrive on aclk; select pin is asynchronous.
// Notes:   Descriptor rings live in the internal descriptor RAM.
// Notes on behaviour
// RULE_01 - Slave select negation closes open receive buffer with last set.
// RULE_02 - Receiver overrun in slave mode sets overrun flag in receive status.
// RULE_03 - Select asserted in master mode closes open buffers with conflict flag.
// RULE_04 - Closing a receive descriptor writes its byte count once.
// RULE_05 - Software gives receive descriptors an even buffer pointer.
// RULE_06 - Transmit descriptor: status word, length word, two pointer words.
// RULE_07 - Ready clears after send or error; software leaves it alone meanwhile.
// RULE_08 - After a wrap descriptor the ring restarts at its base.
// RULE_09 - Interrupt flag selects whether done or error event is raised.
// RULE_10 - Last flag marks the buffer ending the message.
// RULE_11 - Continuous flag in master mode keeps ready set after closing.
// RULE_12 - Slave underrun sets underrun flag and raises transmit error event.
// RULE_13 - Transmit length is read only, never written by hardware.
// RULE_14 - Software aligns transmit pointers for wide characters.
// RULE_15 - Event register readable always; writing one clears a bit.
// RULE_16 - Interrupt stays asserted while any enabled event bit is set.
// RULE_17 - Event bits: conflict 5, tx error 4, no buffer 2, tx 1, rx 0.
// RULE_18 - Select driven active while master raises the conflict event.
// RULE_19 - Character with no free receive buffer is dropped; no-buffer event.
// RULE_20 - Transmit done event when last character enters the transmit FIFO.
// RULE_21 - Receive done event only after last store and descriptor close.
// RULE_22 - Enable register mirrors event layout; both reset to zero.
// RULE_23 - Empty flag clears on fill or abort; full descriptor not reused.
// RULE_24 - Full receive buffer closes and reception continues in next one.
// RULE_25 - Reserved event and enable bits read zero and ignore writes.
`timescale 1ns/1ps
`include "spd_defs.svh"
module spd_desc_events
  import spd_pkg::*;
#(
  parameter int BD_AW = 6
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic         awvalid,
  output logic              awready,
  input  wire logic [11:0]  awaddr,
  input  wire logic         wvalid,
  output logic              wready,
  input  wire logic [31:0]  wdata,
  input  wire logic [3:0]   wstrb,
  output logic              bvalid,
  input  wire logic         bready,
  output logic [1:0]        bresp,
  input  wire logic         arvalid,
  output logic              arready,
  input  wire logic [11:0]  araddr,
  output logic              rvalid,
  input  wire logic         rready,
  output logic [31:0]       rdata,
  output logic [1:0]        rresp,
  input  wire spd_link_ev_t link_ev,
  input  wire logic         peripheral_select_input_n,
  output logic              rx_store_valid,
  output spd_store_t        rx_store,
  output logic [31:0]       tx_fetch_addr,
  output logic              tx_ready,
  output logic              tx_msg_end,
  output logic              irq
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [15:0]      bd_ram [2**BD_AW];
  logic [7:0]       ev;
  logic [7:0]       ev_en;
  logic             master;
  logic [BD_AW-1:0] rx_base;
  logic [BD_AW-1:0] tx_base;
  logic [15:0]      max_rx_buffer_len;
  logic [BD_AW-1:0] rx_wa;
  logic [BD_AW-1:0] tx_wa;
  logic [15:0]      rx_cnt;
  logic [15:0]      tx_cnt;
  logic             rx_ov;
  logic             sel_s1;
  logic             sel_s2;
  logic             sel_q;
  spd_wr_state_t    wr_st;
  logic             aw_have;
  logic             w_have;
  logic [11:0]      aw_addr;
  logic [31:0]      w_data;
  logic [3:0]       w_strb;

  logic [7:0]       next_ev;
  logic [BD_AW-1:0] next_rx_wa;
  logic [BD_AW-1:0] next_tx_wa;
  logic [15:0]      next_rx_cnt;
  logic [15:0]      next_tx_cnt;
  logic             next_rx_ov;
  logic             rx_close;
  logic             tx_close;
  logic [15:0]      rx_st_new;
  logic [15:0]      tx_st_new;
  logic [15:0]      rcnt;
  logic [15:0]      tcnt;
  logic             store;
  logic             next_msg_end;

  // ----------------------------------------
  // Select pin synchroniser and edges
  // ----------------------------------------
  logic sel_act;
  logic sel_rise;
  logic sel_fall;
  assign sel_act  = ~sel_s2;
  assign sel_rise = sel_act & ~sel_q;
  assign sel_fall = ~sel_act & sel_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sel_s1 <= 1'b1;
      sel_s2 <= 1'b1;
      sel_q  <= 1'b0;
    end else begin
      sel_s1 <= peripheral_select_input_n;
      sel_s2 <= sel_s1;
      sel_q  <= sel_act;
    end
  end

  // ----------------------------------------
  // Current descriptors
  // ----------------------------------------
  logic [15:0] rx_st;
  logic [31:0] rx_ptr;
  logic [15:0] tx_st;
  logic [15:0] tx_len;
  logic [31:0] tx_ptr;
  assign rx_st  = bd_ram[rx_wa];
  assign rx_ptr = {bd_ram[rx_wa + BD_AW'(2)], bd_ram[rx_wa + BD_AW'(3)]};
  assign tx_st  = bd_ram[tx_wa];
  assign tx_len = bd_ram[tx_wa + BD_AW'(1)]; // see RULE_06
  assign tx_ptr = {bd_ram[tx_wa + BD_AW'(2)], bd_ram[tx_wa + BD_AW'(3)]};

  // ----------------------------------------
  // Bus write decode
  // ----------------------------------------
  logic        do_wr;
  logic [31:0] wmask;
  logic [7:0]  ev_clr;
  assign do_wr  = (wr_st == SPD_WR_IDLE) & aw_have & w_have;
  assign wmask  = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
  assign ev_clr = (do_wr && aw_addr == `SPD_OFF_EVENT) ?
                  (w_data[7:0] & wmask[7:0] & `SPD_EV_USED) : 8'h00;

  // ----------------------------------------
  // Descriptor engine
  // ----------------------------------------
  always_comb begin
    next_ev      = ev & ~ev_clr;
    next_rx_wa   = rx_wa;
    next_tx_wa   = tx_wa;
    next_rx_ov   = rx_ov;
    next_msg_end = 1'b0;
    rx_close     = 1'b0;
    tx_close     = 1'b0;
    store        = 1'b0;
    rcnt         = rx_cnt;
    tcnt         = tx_cnt;
    rx_st_new    = rx_st;
    tx_st_new    = tx_st;
    if (link_ev.rx_char) begin
      if (rx_st[`SPD_BD_RDY]) begin
        store = 1'b1;
        rcnt  = rx_cnt + 16'h0001;
        if (rcnt >= max_rx_buffer_len) begin
          rx_close = 1'b1; // see RULE_24
        end
      end else begin
        next_ev[`SPD_EV_BSY] = 1'b1; // see RULE_19
      end
    end
    if (link_ev.rx_overrun && !master && rx_st[`SPD_BD_RDY]) begin
      next_rx_ov = 1'b1; // see RULE_02
    end
    if (sel_fall && !master && rcnt != 16'h0000) begin
      rx_close = 1'b1;
      rx_st_new[`SPD_BD_LAST] = 1'b1; // see RULE_01
    end
    if (sel_rise && master) begin
      next_ev[`SPD_EV_MME] = 1'b1; // see RULE_18
      if (rcnt != 16'h0000) begin
        rx_close = 1'b1;
        rx_st_new[`SPD_BD_ME] = 1'b1; // see RULE_03
      end
    end
    if (rx_close) begin
      rx_st_new[`SPD_BD_ERR] = next_rx_ov;
      // Empty clears unless a master keeps the buffer for continuous use.
      if (!(master && rx_st[`SPD_BD_CONT])) begin
        rx_st_new[`SPD_BD_RDY] = 1'b0; // see RULE_23
      end
      if (rx_st[`SPD_BD_INT]) begin
        next_ev[`SPD_EV_RXB] = 1'b1; // see RULE_21
      end
      next_rx_wa = rx_st[`SPD_BD_WRAP] ? rx_base : rx_wa + BD_AW'(4);
      next_rx_ov = 1'b0;
    end
    next_rx_cnt = rx_close ? 16'h0000 : rcnt;
    if (tx_st[`SPD_BD_RDY]) begin
      if (link_ev.tx_taken) begin
        tcnt = tx_cnt + 16'h0001;
        if (tcnt >= tx_len) begin
          tx_close = 1'b1;
          if (tx_st[`SPD_BD_INT]) begin
            next_ev[`SPD_EV_TXB] = 1'b1; // see RULE_20
          end
          next_msg_end = tx_st[`SPD_BD_LAST]; // see RULE_10
        end
      end
      if (link_ev.tx_underrun && !master) begin
        tx_close = 1'b1;
        tx_st_new[`SPD_BD_ERR] = 1'b1; // see RULE_12
      end
      if (sel_rise && master && tx_cnt != 16'h0000) begin
        tx_close = 1'b1;
        tx_st_new[`SPD_BD_ME] = 1'b1; // see RULE_03
      end
      if (tx_close && (tx_st_new[`SPD_BD_ERR] | tx_st_new[`SPD_BD_ME])) begin
        next_msg_end = 1'b0;
        if (tx_st[`SPD_BD_INT]) begin
          next_ev[`SPD_EV_TXE] = 1'b1; // see RULE_09
        end
      end
    end
    if (tx_close) begin
      if (!(master && tx_st[`SPD_BD_CONT])) begin
        tx_st_new[`SPD_BD_RDY] = 1'b0; // see RULE_07 see RULE_11
      end
      next_tx_wa = tx_st[`SPD_BD_WRAP] ? tx_base : tx_wa + BD_AW'(4); // see RULE_08
    end
    // A control write restarts both rings at their new bases, as reset does.
    if (do_wr && aw_addr == `SPD_OFF_CTRL) begin
      next_rx_wa = w_strb[1] ? w_data[8 +: BD_AW] : rx_base; // see RULE_08
      next_tx_wa = w_strb[2] ? w_data[16 +: BD_AW] : tx_base; // see RULE_08
    end
    next_tx_cnt = tx_close ? 16'h0000 : tcnt;
  end

  // Status words and receive byte counts are written back; length words of transmit
  // descriptors are never touched by the engine.
  always_ff @(posedge aclk) begin
    if (do_wr && aw_addr >= `SPD_OFF_BDRAM && aw_addr[1:0] == 2'b00 &&
        aw_addr < `SPD_OFF_BDRAM + 12'(4 * 2**BD_AW)) begin
      bd_ram[aw_addr[BD_AW+1:2]] <= (bd_ram[aw_addr[BD_AW+1:2]] & ~wmask[15:0]) |
                                    (w_data[15:0] & wmask[15:0]);
    end
    if (rx_close) begin
      bd_ram[rx_wa]               <= rx_st_new;
      bd_ram[rx_wa + BD_AW'(1)]   <= rcnt; // see RULE_04
    end
    if (tx_close) begin
      bd_ram[tx_wa] <= tx_st_new; // see RULE_13
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ev             <= `SPD_EV_RST;
      rx_wa          <= '0;
      tx_wa          <= '0;
      rx_cnt         <= 16'h0000;
      tx_cnt         <= 16'h0000;
      rx_ov          <= 1'b0;
      irq            <= 1'b0;
      rx_store_valid <= 1'b0;
      rx_store       <= '0;
      tx_fetch_addr  <= 32'h0000_0000;
      tx_ready       <= 1'b0;
      tx_msg_end     <= 1'b0;
    end else begin
      ev             <= next_ev; // see RULE_15 see RULE_17
      rx_wa          <= next_rx_wa;
      tx_wa          <= next_tx_wa;
      rx_cnt         <= next_rx_cnt;
      tx_cnt         <= next_tx_cnt;
      rx_ov          <= next_rx_ov;
      irq            <= |(next_ev & ev_en); // see RULE_16
      rx_store_valid <= store;
      rx_store.addr  <= rx_ptr + {16'h0000, rx_cnt};
      rx_store.data  <= link_ev.rx_data;
      tx_fetch_addr  <= tx_ptr + {16'h0000, next_tx_cnt};
      tx_ready       <= bd_ram[next_tx_wa][`SPD_BD_RDY];
      tx_msg_end     <= next_msg_end;
    end
  end

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  logic [31:0] ctrl_q;
  logic [31:0] next_ctrl;
  logic [7:0]  next_ev_en;
  logic [15:0] next_mrbl;
  assign ctrl_q = {8'h00, 2'b00, tx_base, 2'b00, rx_base, 7'h00, master};

  always_comb begin
    next_ctrl  = ctrl_q;
    next_ev_en = ev_en;
    next_mrbl  = max_rx_buffer_len;
    if (do_wr && aw_addr == `SPD_OFF_ENABLE) begin
      next_ev_en = ((ev_en & ~wmask[7:0]) | (w_data[7:0] & wmask[7:0])) &
                   `SPD_EV_USED; // see RULE_22 see RULE_25
    end
    if (do_wr && aw_addr == `SPD_OFF_CTRL) begin
      next_ctrl = (ctrl_q & ~wmask) | (w_data & wmask);
    end
    if (do_wr && aw_addr == `SPD_OFF_RXLEN) begin
      next_mrbl = (max_rx_buffer_len & ~wmask[15:0]) | (w_data[15:0] & wmask[15:0]);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ev_en             <= `SPD_EN_RST;
      master            <= 1'b0;
      rx_base           <= '0;
      tx_base           <= '0;
      max_rx_buffer_len <= 16'h0000;
    end else begin
      ev_en             <= next_ev_en;
      master            <= next_ctrl[0];
      rx_base           <= next_ctrl[8 +: BD_AW];
      tx_base           <= next_ctrl[16 +: BD_AW];
      max_rx_buffer_len <= next_mrbl;
    end
  end

  // ----------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------
  spd_wr_state_t next_wr_st;
  logic          next_aw_have;
  logic          next_w_have;
  logic          next_bvalid;
  logic [1:0]    next_bresp;
  logic [11:0]   next_aw_addr;
  logic [31:0]   next_w_data;
  logic [3:0]    next_w_strb;
  logic          wr_ok;
  assign wr_ok = aw_addr[1:0] == 2'b00 &&
                 (aw_addr <= `SPD_OFF_STATUS ||
                  (aw_addr >= `SPD_OFF_BDRAM &&
                   aw_addr < `SPD_OFF_BDRAM + 12'(4 * 2**BD_AW)));

  always_comb begin
    next_wr_st   = wr_st;
    next_aw_have = aw_have;
    next_w_have  = w_have;
    next_aw_addr = aw_addr;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    next_bvalid  = bvalid;
    next_bresp   = bresp;
    if (awvalid && awready) begin
      next_aw_have = 1'b1;
      next_aw_addr = awaddr;
    end
    if (wvalid && wready) begin
      next_w_have = 1'b1;
      next_w_data = wdata;
      next_w_strb = wstrb;
    end
    case (wr_st)
      SPD_WR_IDLE: begin
        if (do_wr) begin
          next_aw_have = 1'b0;
          next_w_have  = 1'b0;
          next_bvalid  = 1'b1;
          next_bresp   = wr_ok ? `SPD_RESP_OKAY : `SPD_RESP_SLVERR;
          next_wr_st   = SPD_WR_RESP;
        end
      end
      SPD_WR_RESP: begin
        if (bready) begin
          next_bvalid = 1'b0;
          next_wr_st  = SPD_WR_IDLE;
        end
      end
      default: next_wr_st = SPD_WR_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_st   <= SPD_WR_IDLE;
      aw_have <= 1'b0;
      w_have  <= 1'b0;
      aw_addr <= 12'h000;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
      bvalid  <= 1'b0;
      bresp   <= `SPD_RESP_OKAY;
      awready <= 1'b0;
      wready  <= 1'b0;
    end else begin
      wr_st   <= next_wr_st;
      aw_have <= next_aw_have;
      w_have  <= next_w_have;
      aw_addr <= next_aw_addr;
      w_data  <= next_w_data;
      w_strb  <= next_w_strb;
      bvalid  <= next_bvalid;
      bresp   <= next_bresp;
      awready <= ~next_aw_have & (next_wr_st == SPD_WR_IDLE);
      wready  <= ~next_w_have & (next_wr_st == SPD_WR_IDLE);
    end
  end

  // ----------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------
  logic        next_rvalid;
  logic [31:0] next_rdata;
  logic [1:0]  next_rresp;
  logic [31:0] rd_val;
  logic        rd_ok;

  always_comb begin
    rd_val = 32'h0000_0000;
    rd_ok  = araddr[1:0] == 2'b00;
    case (araddr)
      `SPD_OFF_EVENT:  rd_val = {24'h000000, ev};
      `SPD_OFF_ENABLE: rd_val = {24'h000000, ev_en};
      `SPD_OFF_CTRL:   rd_val = ctrl_q;
      `SPD_OFF_RXLEN:  rd_val = {16'h0000, max_rx_buffer_len};
      `SPD_OFF_STATUS: rd_val = {8'h00, 2'b00, tx_wa, 8'h00, 2'b00, rx_wa};
      default: begin
        if (araddr >= `SPD_OFF_BDRAM &&
            araddr < `SPD_OFF_BDRAM + 12'(4 * 2**BD_AW)) begin
          rd_val = {16'h0000, bd_ram[araddr[BD_AW+1:2]]};
        end else begin
          rd_ok = 1'b0;
        end
      end
    endcase
    next_rvalid = rvalid;
    next_rdata  = rdata;
    next_rresp  = rresp;
    if (rvalid && rready) begin
      next_rvalid = 1'b0;
    end
    if (arvalid && arready) begin
      next_rvalid = 1'b1;
      next_rdata  = rd_ok ? rd_val : 32'h0000_0000;
      next_rresp  = rd_ok ? `SPD_RESP_OKAY : `SPD_RESP_SLVERR;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= `SPD_RESP_OKAY;
      arready <= 1'b0;
    end else begin
      rvalid  <= next_rvalid;
      rdata   <= next_rdata;
      rresp   <= next_rresp;
      arready <= ~next_rvalid;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_conflict;
    master ##0 sel_rise;
  endsequence

  sequence s_tx_err_close;
    link_ev.tx_underrun && !master && tx_st[`SPD_BD_RDY] && tx_st[`SPD_BD_INT];
  endsequence

  AST_IRQ_FOLLOWS: assert property ( // see RULE_16
    (|(ev & ev_en)) && ev_clr == 8'h00 |=> irq)
    else $error("interrupt dropped while enabled event pending");
  AST_IRQ_QUIET: assert property ( // see RULE_16
    (ev == 8'h00) |-> !irq) else $error("interrupt with no event");
  AST_EV_RESERVED: assert property ( // see RULE_25
    (ev & ~`SPD_EV_USED) == 8'h00 && (ev_en & ~`SPD_EV_USED) == 8'h00)
    else $error("reserved event bit set");
  AST_MME_SET: assert property ( // see RULE_18
    s_conflict |=> ev[`SPD_EV_MME]) else $error("conflict event missed");
  AST_BSY_SET: assert property ( // see RULE_19
    link_ev.rx_char && !rx_st[`SPD_BD_RDY] |=> ev[`SPD_EV_BSY])
    else $error("no-buffer event missed");
  AST_RX_LEN: assert property ( // see RULE_04
    rx_close |=> bd_ram[$past(rx_wa) + BD_AW'(1)] == $past(rcnt))
    else $error("receive length not written");
  AST_TX_ERR: assert property ( // see RULE_12
    s_tx_err_close |=> ev[`SPD_EV_TXE] ##0 !tx_msg_end)
    else $error("underrun error event missed");
  AST_W1C: assert property ( // see RULE_15
    ev_clr[`SPD_EV_RXB] && !(rx_close && rx_st[`SPD_BD_INT]) |=> !ev[`SPD_EV_RXB])
    else $error("event bit not cleared");
  AST_TX_RDY_CLR: assert property ( // see RULE_07
    tx_close && !(master && tx_st[`SPD_BD_CONT]) && !(do_wr && aw_addr >= `SPD_OFF_BDRAM)
    |=> !bd_ram[$past(tx_wa)][`SPD_BD_RDY])
    else $error("ready not cleared on close");

endmodule

// File: spd_defs.svh
// Purpose: Offsets, field positions and reset values of the descriptor engine.
// Assumes: Included by the design and by the bench.
// Notes:   Definitions only.
`ifndef SPD_DEFS_SVH
`define SPD_DEFS_SVH
`define SPD_OFF_EVENT   12'h000
`define SPD_OFF_ENABLE  12'h004
`define SPD_OFF_CTRL    12'h008
`define SPD_OFF_RXLEN   12'h00c
`define SPD_OFF_STATUS  12'h010
`define SPD_OFF_BDRAM   12'h100
`define SPD_EV_RXB      0
`define SPD_EV_TXB      1
`define SPD_EV_BSY      2
`define SPD_EV_TXE      4
`define SPD_EV_MME      5
`define SPD_EV_USED     8'h37
`define SPD_EV_RST      8'h00
`define SPD_EN_RST      8'h00
`define SPD_BD_RDY      15
`define SPD_BD_WRAP     13
`define SPD_BD_INT      12
`define SPD_BD_LAST     11
`define SPD_BD_CONT     9
`define SPD_BD_ERR      1
`define SPD_BD_ME       0
`define SPD_RESP_OKAY   2'b00
`define SPD_RESP_SLVERR 2'b10
`endif

// File: spd_pkg.sv
// Purpose: Types shared by the descriptor engine and its bench.
// Assumes: Nothing.
// Notes:   Constants live in spd_defs.svh.
package spd_pkg;
  typedef enum logic [0:0] {
    SPD_WR_IDLE = 1'b0,
    SPD_WR_RESP = 1'b1
  } spd_wr_state_t;
  typedef struct packed {
    logic       rx_char;
    logic [7:0] rx_data;
    logic       rx_overrun;
    logic       tx_taken;
    logic       tx_underrun;
  } spd_link_ev_t;
  typedef struct packed {
    logic [31:0] addr;
    logic [7:0]  data;
  } spd_store_t;
endpackage

// File: spd_peer.sv
// Purpose: Far-side serial peer that drives the link events and the select pin.
// Assumes: Its tasks are called just after a rising aclk edge.
// Notes:   Idle data shows the inverse of the last byte sent.
`timescale 1ns/1ps
module spd_peer
  import spd_pkg::*;
(
  input  wire logic    aclk,
  output spd_link_ev_t link_ev,
  output logic         sel_n
);
  initial begin
    link_ev = '0;
    sel_n   = 1'b1;
  end
  task automatic pulse(input spd_link_ev_t ev);
    link_ev <= ev;
    @(posedge aclk);
    link_ev <= '{rx_data: ~ev.rx_data, default: 1'b0};
    @(posedge aclk);
  endtask
  // The wait covers the two-flop synchroniser and the close that follows it.
  task automatic set_select(input logic on);
    sel_n <= ~on;
    repeat (6) @(posedge aclk);
  endtask
endmodule

// File: spd_desc_events_bench.sv
// Purpose: Self-checking bench of the descriptor status and event block.
// Assumes: Descriptor rings in the internal descriptor RAM.
// Notes:   Expected reads and stores are noted in queues and checked by a monitor.
`timescale 1ns/1ps
`include "spd_defs.svh"
module spd_desc_events_bench
  import spd_pkg::*;
;
  logic         aclk;
  logic         aresetn;
  logic         awvalid, wvalid, bready, arvalid, rready;
  logic [11:0]  awaddr, araddr;
  logic [31:0]  wdata;
  logic [3:0]   wstrb;
  logic         awready, wready, bvalid, arready, rvalid, rx_store_valid, tx_ready;
  logic         tx_msg_end, irq, sel_n;
  logic [1:0]   bresp, rresp;
  logic [31:0]  rdata, tx_fetch_addr;
  spd_store_t   rx_store;
  spd_link_ev_t link_ev;
  int           bad_count = 0;
  int           compares = 0;
  logic [65:0]  rd_q[$];
  spd_store_t   st_q[$];
  logic         end_q[$];
  logic [1:0]   br_q[$];

  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  spd_desc_events DUT (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
    .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .link_ev(link_ev), .peripheral_select_input_n(sel_n), .rx_store_valid(rx_store_valid),
    .rx_store(rx_store), .tx_fetch_addr(tx_fetch_addr), .tx_ready(tx_ready),
    .tx_msg_end(tx_msg_end), .irq(irq));

  spd_peer peer (.aclk(aclk), .link_ev(link_ev), .sel_n(sel_n));

  // ----------------------------------------
  // Checking and bus tasks
  // ----------------------------------------
  task automatic chk(input logic [65:0] seen, input logic [65:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic complete_run;
    if (bad_count == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic [1:0] r = `SPD_RESP_OKAY, input logic [3:0] s = 4'hf);
    br_q.push_back(r);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= s;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e,
                    input logic [1:0] r = `SPD_RESP_OKAY);
    rd_q.push_back({r, m, e & m});
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rx_bytes(input int n);
    logic [7:0] d;
    for (int k = 0; k < n; k++) begin
      d = 8'($urandom);
      st_q.push_back('{addr: 32'h1000 + 32'(k), data: d});
      peer.pulse('{rx_char: 1'b1, rx_data: d, default: 1'b0});
    end
  endtask

  always @(posedge aclk) begin
    logic [65:0] note;
    if (rvalid === 1'b1 && rready === 1'b1) begin
      note = rd_q.size() ? rd_q.pop_front() : 'x;
      chk({rresp, rdata & note[63:32]}, {note[65:64], note[31:0]});
    end
    if (aresetn === 1'b1 && rx_store_valid !== 1'b0) begin
      chk(rx_store, st_q.size() ? st_q.pop_front() : 'x);
    end
    if (aresetn === 1'b1 && tx_msg_end !== 1'b0) begin
      chk(end_q.size() ? end_q.pop_front() : 1'b0, 1'b1);
    end
    if (bvalid === 1'b1 && bready === 1'b1) begin
      chk(bresp, br_q.size() ? br_q.pop_front() : 'x);
    end
  end

  initial begin
    repeat (20000) @(posedge aclk);
    bad_count++;
    complete_run();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(16671));
    aresetn <= 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} <= 5'h00;
    {awaddr, araddr, wdata, wstrb} <= 60'h0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rd(`SPD_OFF_EVENT, '1, 32'h0);
    rd(`SPD_OFF_ENABLE, '1, 32'h0);
    rd(12'h0f0, '1, 32'h0, `SPD_RESP_SLVERR);
    wr(12'h0f0, 32'h1, `SPD_RESP_SLVERR);
    wr(`SPD_OFF_ENABLE, 32'hff);
    rd(`SPD_OFF_ENABLE, '1, 32'h37);
    wr(`SPD_OFF_ENABLE, 32'h0, `SPD_RESP_OKAY, 4'he);
    rd(`SPD_OFF_ENABLE, '1, 32'h37);
    // Slave mode, rx ring at word 0, tx ring at word 8, buffers of four bytes.
    wr(`SPD_OFF_CTRL, 32'h00080000);
    wr(`SPD_OFF_RXLEN, 32'h4);
    wr(12'h108, 32'h0);
    wr(12'h10c, 32'h1000);
    wr(12'h100, 32'hb000);
    peer.set_select(1'b1);
    rx_bytes(2);
    peer.pulse('{rx_overrun: 1'b1, default: 1'b0});
    peer.set_select(1'b0);
    rd(12'h100, '1, 32'h3802);
    rd(12'h104, '1, 32'h2);
    rd(`SPD_OFF_EVENT, '1, 32'h01);
    chk(irq, 1'b1);
    peer.set_select(1'b1);
    peer.pulse('{rx_char: 1'b1, rx_data: 8'($urandom), default: 1'b0});
    rd(`SPD_OFF_EVENT, '1, 32'h05);
    wr(`SPD_OFF_EVENT, 32'h01);
    rd(`SPD_OFF_EVENT, '1, 32'h04);
    chk(irq, 1'b1);
    wr(`SPD_OFF_EVENT, 32'h04);
    rd(`SPD_OFF_EVENT, '1, 32'h00);
    chk(irq, 1'b0);
    wr(12'h100, 32'h9000);
    rx_bytes(4);
    rd(12'h100, '1, 32'h1000);
    rd(12'h104, '1, 32'h4);
    peer.set_select(1'b0);
    // Transmit ring of one descriptor at word 8.
    wr(12'h124, 32'h2);
    wr(12'h128, 32'h0);
    wr(12'h12c, 32'h2000);
    wr(12'h120, 32'hb800);
    chk(tx_ready, 1'b1);
    chk(tx_fetch_addr, 32'h2000);
    wr(`SPD_OFF_EVENT, 32'hff);
    end_q.push_back(1'b1);
    repeat (2) peer.pulse('{tx_taken: 1'b1, default: 1'b0});
    rd(12'h120, '1, 32'h3800);
    rd(12'h124, '1, 32'h2);
    rd(`SPD_OFF_EVENT, '1, 32'h02);
    rd(`SPD_OFF_STATUS, 32'h003f0000, 32'h00080000);
    chk(tx_ready, 1'b0);
    wr(`SPD_OFF_EVENT, 32'hff);
    wr(12'h120, 32'hb000);
    peer.pulse('{tx_underrun: 1'b1, default: 1'b0});
    rd(12'h120, 32'h8002, 32'h0002);
    rd(`SPD_OFF_EVENT, 32'h10, 32'h10);
    // Master mode: conflict on the select pin, then continuous reuse.
    wr(`SPD_OFF_CTRL, 32'h00080001);
    wr(`SPD_OFF_EVENT, 32'hff);
    wr(12'h120, 32'hb000);
    peer.pulse('{tx_taken: 1'b1, default: 1'b0});
    peer.set_select(1'b1);
    rd(12'h120, '1, 32'h3001);
    rd(`SPD_OFF_EVENT, 32'h20, 32'h20);
    peer.set_select(1'b0);
    wr(`SPD_OFF_EVENT, 32'hff);
    wr(12'h124, 32'h1);
    wr(12'h120, 32'ha200);
    peer.pulse('{tx_taken: 1'b1, default: 1'b0});
    rd(12'h120, '1, 32'ha200);
    rd(`SPD_OFF_EVENT, 32'h12, 32'h00);
    chk(tx_ready, 1'b1);
    chk(end_q.size(), 0);
    complete_run();
  end
endmodule
